// [verilog/spi_flash_dev.sv]
// Purpose: Command, busy and protection logic of a serial flash device
// Assumes: i_clk far faster than the link clock; pins synchronised
// Notes:   Array storage lives outside; program is an AND write, erase a range fill
// Behaviour
// - Works with clock idling low or high
// - Sample input rising, change output falling
// - Host enables writes before a program sequence
// - Program up to 256 bytes within page
// - Erase fills sector, block or array with ones
// - Host enables writes before any erase
// - Busy flag set during write cycles
// - Active while selected or cycle running
// - Deep sleep until wake command
// - Deep sleep ignores all but wake
// - Three protect bits select refused range
// - Protect bit plus pin locks status bits
// - OTP lock bit refuses OTP program/erase
// - OTP status write only sets lock
// - Write commands need whole byte count
// - Modifying commands need latch set
// - Latch clears at reset, write disable and accepted writes
// - Top bit 0: none, quarter, half, all
// - Top bit 1: none, sectors 0-59, 0-61, all
// - Array of 64 sectors, four blocks
// - Deselected output released; first fall needed
// - Opcode first, MSB first, address follows
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module spi_flash_dev
	import spi_flash_pkg::*;
#(
	parameter int         PROG_CYCLES  = 512,
	parameter int         STAT_CYCLES  = 256,
	parameter int         SECT_CYCLES  = 1024,
	parameter int         BLOCK_CYCLES = 2048,
	parameter int         CHIP_CYCLES  = 4096,
	parameter logic [7:0] DEV_ID       = 8'h5a  // Arbitrary identifier value
) (
	input  wire logic            i_clk,
	input  wire logic            i_rst_n,
	spi_flash_if.dev             link,
	output logic                 o_mem_we,
	output logic [AW-1:0]        o_mem_addr,
	output logic [7:0]           o_mem_and_data,
	output logic                 o_erase,
	output logic [AW-1:0]        o_erase_lo,
	output logic [AW-1:0]        o_erase_hi,
	output logic                 o_otp_target,
	output logic                 o_busy,
	output logic                 o_active,
	output logic                 o_sleep,
	output logic [7:0]           o_status
);
	initial begin
		if (PROG_CYCLES <= 256 || PROG_CYCLES >= 2**BUSY_W || STAT_CYCLES < 1 || SECT_CYCLES < 1
			|| BLOCK_CYCLES < 1 || CHIP_CYCLES < 1 || CHIP_CYCLES >= 2**BUSY_W)
			$error("spi_flash_dev: cycle counts out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; edge detect only on second stage onward
	logic cs_s1, cs_s2, cs_s3, ck_s1, ck_s2, ck_s3, si_s1, si_s2, wp_s1, wp_s2;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			{cs_s1, cs_s2, cs_s3} <= 3'h7;
			{ck_s1, ck_s2, ck_s3} <= 3'h0;
			{si_s1, si_s2, wp_s1, wp_s2} <= 4'hf;
		end else begin
			{cs_s1, cs_s2, cs_s3} <= {link.cs_n, cs_s1, cs_s2};
			{ck_s1, ck_s2, ck_s3} <= {link.sclk, ck_s1, ck_s2};
			{si_s1, si_s2, wp_s1, wp_s2} <= {link.si, si_s1, link.wp_n, wp_s1};
		end
	end

	logic        armed, in_frame, busy, sleep, wr_latch, stat_prot, otp, otp_lock;
	logic [2:0]  bp;
	logic [2:0]  bit_cnt;
	logic [8:0]  byte_cnt;
	logic [6:0]  sh;
	logic [7:0]  opcode, tx;
	logic [23:0] a;

	wire       cs_fall  = cs_s3 & ~cs_s2;
	wire       cs_rise  = cs_s2 & ~cs_s3;
	wire       ck_rise  = ck_s2 & ~ck_s3 & in_frame;
	wire       ck_fall  = ck_s3 & ~ck_s2 & in_frame;
	wire       byte_end = ck_rise && bit_cnt == 3'h7;
	wire [7:0] byte_in  = {sh, si_s2};
	wire [7:0] cur_op   = (byte_cnt == 9'h0) ? byte_in : opcode;
	wire [7:0] status   = {(otp ? otp_lock : stat_prot), 2'h0, bp, wr_latch, busy};

	////////////////////////////////////////////////////////////////////////
	// Target range and protection decode
	function automatic logic prot_at(input logic [2:0] sel, input logic [AW-1:0] ad);
		unique case (sel)
			3'b001:  prot_at = ad >= Q3_BASE;
			3'b010:  prot_at = ad >= H2_BASE;
			3'b101:  prot_at = ad < S60_BASE;
			3'b110:  prot_at = ad < S62_BASE;
			3'b011,
			3'b111:  prot_at = 1'b1;
			default: prot_at = 1'b0;
		endcase
	endfunction : prot_at

	wire          is_sect = opcode == OP_SECT_ERASE;
	wire          is_blk  = opcode == OP_BLK_ERASE_A || opcode == OP_BLK_ERASE_B;
	wire          is_ce   = opcode == OP_CE_A || opcode == OP_CE_B;
	wire          is_prog = opcode == OP_PROGRAM;
	wire [AW-1:0] tgt     = a[AW-1:0];
	// sector n starts at n*1000h, block at 10000h steps
	wire [AW-1:0] rng_lo  = is_ce ? '0 : is_sect ? {tgt[17:12], 12'h000}
	                      : is_blk ? {tgt[17:16], 16'h0000} : {tgt[17:8], 8'h00};
	wire [AW-1:0] rng_hi  = is_ce ? ADDR_MAX : is_sect ? {tgt[17:12], 12'hfff}
	                      : is_blk ? {tgt[17:16], 16'hffff} : {tgt[17:8], 8'hff};
	wire          refused = otp ? (otp_lock | is_ce)
	                      : (prot_at(bp, rng_lo) | prot_at(bp, rng_hi));
	wire          hw_prot = stat_prot & ~wp_s2;

	wire cmd_ok     = cs_rise && in_frame && bit_cnt == 3'h0 && !sleep && !busy;
	wire do_wr_en   = cmd_ok && opcode == OP_WR_ENABLE && byte_cnt == 9'h1;
	wire do_wr_dis  = cmd_ok && opcode == OP_WR_DISABLE && byte_cnt == 9'h1;
	wire do_otp     = cmd_ok && opcode == OP_OTP && byte_cnt == 9'h1;
	wire do_sleep   = cmd_ok && opcode == OP_SLEEP && byte_cnt == 9'h1;
	wire do_stat_wr = cmd_ok && wr_latch && opcode == OP_STAT_WRITE && byte_cnt == 9'h2
	                  && (otp || !hw_prot);
	wire do_prog    = cmd_ok && wr_latch && is_prog && byte_cnt >= 9'h5 && !refused;
	wire do_ers     = cmd_ok && wr_latch && !refused
	                  && (((is_sect || is_blk) && byte_cnt == 9'h4) || (is_ce && byte_cnt == 9'h1));
	wire do_wake    = cs_rise && in_frame && sleep && opcode == OP_WAKE_ID && byte_cnt != 9'h0;
	wire [BUSY_W-1:0] ers_len = is_ce ? BUSY_W'(CHIP_CYCLES - 1)
	                          : is_blk ? BUSY_W'(BLOCK_CYCLES - 1) : BUSY_W'(SECT_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////
	// Frame tracking and shift-in
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			armed    <= 1'b0;
			in_frame <= 1'b0;
			bit_cnt  <= 3'h0;
			byte_cnt <= 9'h0;
			sh       <= 7'h0;
			opcode   <= 8'h00;
			a        <= 24'h0;
		end else begin
			if (cs_s2)
				armed <= 1'b1;
			if (cs_fall) begin
				in_frame <= armed;
				bit_cnt  <= 3'h0;
				byte_cnt <= 9'h0;
			end else if (cs_s2) begin
				in_frame <= 1'b0;
			end else if (ck_rise) begin
				bit_cnt <= bit_cnt + 3'h1;
				sh      <= byte_in[6:0];
				if (byte_end && byte_cnt != 9'h1ff)
					byte_cnt <= byte_cnt + 9'h1;
				if (byte_end && byte_cnt == 9'h0)
					opcode <= byte_in;
				if (byte_end && byte_cnt >= 9'h1 && byte_cnt <= 9'h3)
					a <= {a[15:0], byte_in};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Page buffer, filled only while idle so a running program is not disturbed
	logic [7:0]         pbuf [PAGE_LEN];
	logic [PAGE_LEN-1:0] pvalid;
	wire  [7:0]         pidx   = 8'(a[7:0] + 8'(byte_cnt - 9'h4));
	wire                pcatch = byte_end && !busy && !sleep && is_prog && byte_cnt >= 9'h4;
	always_ff @(posedge i_clk) begin
		if (pcatch)
			pbuf[pidx] <= byte_in;
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || (cs_fall && !busy))
			pvalid <= '0;
		else if (pcatch)
			pvalid[pidx] <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Status, latch and power state
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wr_latch  <= 1'b0;
			stat_prot <= 1'b0;
			bp        <= 3'h0;
			otp       <= 1'b0;
			otp_lock  <= 1'b0;
			sleep     <= 1'b0;
		end else begin
			if (do_wr_en)
				wr_latch <= 1'b1;
			else if (do_wr_dis || do_stat_wr || do_prog || do_ers)
				wr_latch <= 1'b0;
			if (do_otp)
				otp <= 1'b1;
			else if (do_wr_dis)
				otp <= 1'b0;
			if (do_stat_wr && otp)
				otp_lock <= 1'b1;
			else if (do_stat_wr) begin
				stat_prot <= a[SB_LOCK];
				bp        <= a[SB_BP_LO +: 3];
			end
			if (do_sleep)
				sleep <= 1'b1;
			else if (do_wake)
				sleep <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Internal cycle: counts down; program walks the page buffer first
	logic [BUSY_W-1:0] busy_cnt;
	logic [8:0]        widx;
	logic [AW-9:0]     page;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			busy     <= 1'b0;
			busy_cnt <= '0;
			widx     <= PAGE_LEN;
			page     <= '0;
		end else if (do_stat_wr || do_prog || do_ers) begin
			busy     <= 1'b1;
			busy_cnt <= do_stat_wr ? BUSY_W'(STAT_CYCLES - 1) : do_prog ? BUSY_W'(PROG_CYCLES - 1) : ers_len;
			widx     <= do_prog ? 9'h0 : PAGE_LEN;
			page     <= tgt[AW-1:8];
		end else begin
			if (busy_cnt == '0)
				busy <= 1'b0;
			else
				busy_cnt <= busy_cnt - BUSY_W'(1);
			if (widx != PAGE_LEN)
				widx <= widx + 9'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Array and status outputs
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_mem_we       <= 1'b0;
			o_mem_addr     <= '0;
			o_mem_and_data <= 8'hff;
			o_erase        <= 1'b0;
			o_erase_lo     <= '0;
			o_erase_hi     <= '0;
			o_otp_target   <= 1'b0;
			o_busy         <= 1'b0;
			o_active       <= 1'b0;
			o_sleep        <= 1'b0;
			o_status       <= 8'h00;
		end else begin
			o_mem_we       <= widx != PAGE_LEN && pvalid[widx[7:0]];
			o_mem_addr     <= {page, widx[7:0]};
			o_mem_and_data <= pbuf[widx[7:0]];
			o_erase        <= do_ers;
			if (do_ers) begin
				o_erase_lo <= rng_lo;
				o_erase_hi <= rng_hi;
			end
			if (do_prog || do_ers)
				o_otp_target <= otp;
			o_busy   <= busy;
			o_active <= !cs_s2 || busy;
			o_sleep  <= sleep;
			o_status <= status;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift-out on falling edges; status repeats each byte
	wire [7:0] tx_next = (cur_op == OP_RDSR && !sleep) ? status
	                   : (cur_op == OP_WAKE_ID && byte_cnt >= 9'h3) ? DEV_ID : 8'h00;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			tx           <= 8'h00;
			link.so      <= 1'b0;
			link.so_oe_n <= 1'b1;
		end else begin
			link.so_oe_n <= cs_s2 | ~in_frame;
			if (byte_end)
				tx <= tx_next;
			else if (ck_fall) begin
				link.so <= tx[7];
				tx      <= {tx[6:0], 1'b0};
			end
		end
	end
endmodule : spi_flash_dev

// [verilog/spi_flash_pkg.sv]
// Purpose: Shared constants for the serial flash device end and its host end
// Assumes: 18-bit array address, 8-bit opcodes, status byte layout below
// Notes:   Host register offsets are byte addresses on the plain register port
package spi_flash_pkg;
	localparam logic [7:0]  OP_WR_ENABLE   = 8'h06;
	localparam logic [7:0]  OP_WR_DISABLE  = 8'h04;
	localparam logic [7:0]  OP_RDSR        = 8'h05;
	localparam logic [7:0]  OP_STAT_WRITE  = 8'h01;
	localparam logic [7:0]  OP_PROGRAM     = 8'h02;
	localparam logic [7:0]  OP_SECT_ERASE  = 8'h20;
	localparam logic [7:0]  OP_BLK_ERASE_A = 8'hd8;
	localparam logic [7:0]  OP_BLK_ERASE_B = 8'h52;
	localparam logic [7:0]  OP_CE_A  = 8'hc7;
	localparam logic [7:0]  OP_CE_B  = 8'h60;
	localparam logic [7:0]  OP_SLEEP   = 8'hb9;
	localparam logic [7:0]  OP_WAKE_ID = 8'hab;
	localparam logic [7:0]  OP_OTP   = 8'h3a;
	// Status byte fields
	localparam int          SB_BUSY  = 0;
	localparam int          SB_LATCH = 1;
	localparam int          SB_BP_LO = 2;
	localparam int          SB_LOCK  = 7;
	// Array geometry, 262144 bytes
	localparam int          AW       = 18;
	localparam logic [17:0] ADDR_MAX = 18'h3ffff;
	localparam logic [17:0] Q3_BASE  = 18'h30000;
	localparam logic [17:0] H2_BASE  = 18'h20000;
	localparam logic [17:0] S60_BASE = 18'h3c000;
	localparam logic [17:0] S62_BASE = 18'h3e000;
	localparam int          BUSY_W   = 16;
	localparam logic [8:0]  PAGE_LEN = 9'h100;
	// Host register map
	localparam logic [3:0]  HREG_SHIFT  = 4'h0;
	localparam logic [3:0]  HREG_STATUS = 4'h4;
	localparam logic [3:0]  HREG_RX     = 4'h8;
	localparam logic [3:0]  HREG_CFG    = 4'hc;
	localparam int          HW_LAST  = 8;
	localparam int          HC_MODE3 = 0;
	localparam int          HC_WP    = 1;
endpackage : spi_flash_pkg

// [verilog/spi_flash_if.sv]
// Purpose: Four-wire link plus write-protect pin between host and flash device
// Assumes: Device output released by so_oe_n high
// Notes:   Released data line reads as a pulled-up one
`timescale 1ns/100ps
interface spi_flash_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe_n;
	logic wp_n;
	wire  so_line = so_oe_n ? 1'b1 : so;
	modport dev  (input cs_n, input sclk, input si, input wp_n, output so, output so_oe_n);
	modport host (output cs_n, output sclk, output si, output wp_n, input so_line);
endinterface : spi_flash_if

// [verilog/spi_flash_host.sv]
// Purpose: Byte-wise link master driving the serial flash
// Assumes: Software builds each command byte by byte through the shift register
// Notes:   Clock divided from i_clk; one byte in flight, later writes refused
`timescale 1ns/100ps
module spi_flash_host
	import spi_flash_pkg::*;
#(
	parameter int HALF = 12
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	spi_flash_if.host        link,
	input  wire logic [3:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata
);
	initial begin
		if (HALF < 4 || HALF > 255)
			$error("spi_flash_host: HALF out of range");
	end

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_LOW  = 2'b01,
		H_HIGH = 2'b10,
		H_TAIL = 2'b11
	} hstate_t;

	hstate_t    state;
	logic [7:0] cnt, tx, rx, rx_last;
	logic [2:0] bits;
	logic       last, mode3, wp_on, so_s1, so_s2;

	wire start  = i_wr && i_addr == HREG_SHIFT && state == H_IDLE;
	wire cfg_wr = i_wr && i_addr == HREG_CFG;
	wire tick   = cnt == 8'h00;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			{so_s1, so_s2} <= 2'h3;
			mode3          <= 1'b0;
			wp_on          <= 1'b0;
			link.wp_n      <= 1'b1;
			o_rdata        <= 32'h0;
		end else begin
			{so_s1, so_s2} <= {link.so_line, so_s1};
			if (cfg_wr) begin
				mode3 <= i_wdata[HC_MODE3];
				wp_on <= i_wdata[HC_WP];
			end
			link.wp_n <= ~wp_on;
			o_rdata   <= !i_rd ? 32'h0
			           : i_addr == HREG_STATUS ? {30'h0, ~link.cs_n, state != H_IDLE}
			           : i_addr == HREG_RX ? {24'h0, rx_last}
			           : i_addr == HREG_CFG ? {30'h0, wp_on, mode3} : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte engine: data out on falling edge, sampled half a period after rise
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state     <= H_IDLE;
			cnt       <= 8'h00;
			tx        <= 8'h00;
			rx        <= 8'h00;
			rx_last   <= 8'h00;
			bits      <= 3'h0;
			last      <= 1'b0;
			link.cs_n <= 1'b1;
			link.sclk <= 1'b0;
			link.si   <= 1'b0;
		end else begin
			cnt <= tick ? 8'h00 : cnt - 8'h01;
			unique case (state)
				H_IDLE: begin
					if (link.cs_n)
						link.sclk <= mode3;
					if (start) begin
						tx        <= i_wdata[7:0];
						last      <= i_wdata[HW_LAST];
						bits      <= 3'h0;
						link.cs_n <= 1'b0;
						link.sclk <= 1'b0;
						link.si   <= i_wdata[7];
						cnt       <= 8'(HALF - 1);
						state     <= H_LOW;
					end
				end
				H_LOW: begin
					if (tick) begin
						link.sclk <= 1'b1;
						cnt       <= 8'(HALF - 1);
						state     <= H_HIGH;
					end
				end
				H_HIGH: begin
					if (tick) begin
						rx  <= {rx[6:0], so_s2};
						cnt <= 8'(HALF - 1);
						if (bits == 3'h7) begin
							rx_last   <= {rx[6:0], so_s2};
							link.sclk <= mode3;
							state     <= last ? H_TAIL : H_IDLE;
						end else begin
							bits      <= bits + 3'h1;
							tx        <= {tx[6:0], 1'b0};
							link.si   <= tx[6];
							link.sclk <= 1'b0;
							state     <= H_LOW;
						end
					end
				end
				H_TAIL: begin
					if (tick) begin
						link.cs_n <= 1'b1;
						state     <= H_IDLE;
					end
				end
			endcase
		end
	end
endmodule : spi_flash_host

// [verification/spi_flash_monitor.sv]
// Purpose: Wire-level checks on the link between host end and flash end
// Assumes: Host half period of HALF clocks; both ends inside one i_clk domain
// Notes:   Watches the interface only, so both ends are judged together
`timescale 1ns/100ps
module spi_flash_monitor #(
	parameter int HALF = 12
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic si,
	input  wire logic so,
	input  wire logic so_oe_n
);
	logic [7:0] hi_cnt;
	logic [2:0] bit_cnt;

	// Cycles the link clock has stood high
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !sclk) hi_cnt <= 8'h00;
		else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
	end

	// Rising link edges within a frame, modulo one byte
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || cs_n) bit_cnt <= 3'h0;
		else if ($rose(sclk)) bit_cnt <= bit_cnt + 3'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_frame_end;
		$rose(cs_n);
	endsequence
	sequence s_bit_taken;
		$rose(sclk) && !cs_n;
	endsequence

	property p_release;      cs_n [*6] |-> so_oe_n;                                     endproperty
	property p_release_time; s_frame_end |-> ##[1:6] so_oe_n;                            endproperty
	property p_drive_sel;    $fell(so_oe_n) |-> !cs_n;                                   endproperty
	property p_clk_still;    s_frame_end |=> $stable(sclk) [*4];                         endproperty
	property p_si_hold;      s_bit_taken |=> $stable(si) [*3];                           endproperty
	property p_so_fall;      (!so_oe_n && $past(!so_oe_n) && $changed(so)) |-> !sclk;    endproperty
	property p_byte_close;   s_frame_end |-> bit_cnt == 3'h0;                            endproperty
	property p_clk_high;     ($fell(sclk) && !cs_n) |-> hi_cnt >= 8'(HALF - 1);          endproperty

	a_release:      assert property (p_release)      else $error("data line driven while deselected");
	a_release_time: assert property (p_release_time) else $error("data line not released after frame");
	a_drive_sel:    assert property (p_drive_sel)    else $error("data line driven without select");
	a_clk_still:    assert property (p_clk_still)    else $error("link clock moved after frame");
	a_si_hold:      assert property (p_si_hold)      else $error("input bit moved while clock high");
	a_so_fall:      assert property (p_so_fall)      else $error("output bit moved while clock high");
	a_byte_close:   assert property (p_byte_close)   else $error("frame closed off a byte boundary");
	a_clk_high:     assert property (p_clk_high)     else $error("link clock high phase too short");
endmodule : spi_flash_monitor

// [verification/tb_top.sv]
// Purpose: Host end and flash end joined back to back, driven over the register port
// Assumes: Short cycle counts on the flash end keep the run brief
// Notes:   Array writes and fills are captured from the flash end's memory strobes
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
	import spi_flash_pkg::*;
	localparam int         HALF = 6;
	localparam logic [7:0] ID   = 8'h3c;  // Arbitrary identifier value
	logic            i_clk, i_rst_n, i_wr, i_rd;
	logic [3:0]      i_addr;
	logic [31:0]     i_wdata, o_rdata, v;
	logic            mem_we, erase, busy, active, sleep, otp_tgt;
	logic [AW-1:0]   mem_addr, erase_lo, erase_hi, a;
	logic [35:0]     seen;
	logic [7:0]      mem_data, status, dat[8];
	logic [7:0]      ops[5] = '{OP_SECT_ERASE, OP_BLK_ERASE_A, OP_BLK_ERASE_B, OP_CE_A, OP_CE_B};
	logic [5:0]      secs[4] = '{6'h2f, 6'h3c, 6'h3e, 6'h00};
	logic [AW-1:0]   wq_a[$];
	logic [7:0]      wq_d[$];
	int              errors, samples_checked, ecount, n;

	spi_flash_if link_if ();
	spi_flash_host #(.HALF(HALF)) spi_flash_host_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_if),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
	spi_flash_dev #(.PROG_CYCLES(300), .STAT_CYCLES(20), .SECT_CYCLES(60), .BLOCK_CYCLES(80), .CHIP_CYCLES(100),
		.DEV_ID(ID)) spi_flash_dev_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link_if), .o_mem_we(mem_we),
		.o_mem_addr(mem_addr), .o_mem_and_data(mem_data), .o_erase(erase), .o_erase_lo(erase_lo),
		.o_erase_hi(erase_hi), .o_otp_target(otp_tgt), .o_busy(busy), .o_active(active), .o_sleep(sleep),
		.o_status(status));
	spi_flash_monitor #(.HALF(HALF)) spi_flash_monitor_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.cs_n(link_if.cs_n), .sclk(link_if.sclk), .si(link_if.si), .so(link_if.so), .so_oe_n(link_if.so_oe_n));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (mem_we) begin
			wq_a.push_back(mem_addr);
			wq_d.push_back(mem_data);
		end
		if (erase) begin
			ecount++;
			seen <= {erase_lo, erase_hi};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic prot(input logic [2:0] c, input logic [5:0] s);
		case (c)
			3'h1: return s >= 6'h30;
			3'h2: return s >= 6'h20;
			3'h3, 3'h7: return 1'b1;
			3'h5: return s <= 6'h3b;
			3'h6: return s <= 6'h3d;
			default: return 1'b0;
		endcase
	endfunction : prot

	function automatic logic [35:0] span(input logic [7:0] op, input logic [17:0] ad);
		if (op == OP_SECT_ERASE) return {ad[17:12], 12'h000, ad[17:12], 12'hfff};
		if (op == OP_BLK_ERASE_A || op == OP_BLK_ERASE_B) return {ad[17:16], 16'h0000, ad[17:16], 16'hffff};
		return {18'h00000, ADDR_MAX};
	endfunction : span

	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		i_addr  <= ad;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] ad);
		i_addr <= ad;
		i_rd   <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
		@(posedge i_clk);
	endtask : rd

	task automatic send(input logic [7:0] b, input logic last);
		int k;
		k = 0;
		do begin
			rd(HREG_STATUS);
			k++;
		end while (v[0] && k < 200);
		wr(HREG_SHIFT, {23'h0, last, b});
		if (last) begin
			do begin
				rd(HREG_STATUS);
				k++;
			end while (v[1:0] != 2'b00 && k < 400);
			`CHK("link idle", 1'b1, k < 400)
			// Leaves room for the flash end to see select high and finish the command
			repeat (12) @(posedge i_clk);
		end
	endtask : send

	task automatic cmd(input logic [31:0] w, input int nb, input logic fin = 1'b1);
		for (int i = 0; i < nb; i++) begin
			send(w[31-8*i -: 8], fin && i == nb - 1);
		end
	endtask : cmd

	task automatic settle();
		for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge i_clk);
		repeat (2) @(posedge i_clk);
	endtask : settle

	task automatic stat_write(input logic [7:0] s);
		cmd({OP_WR_ENABLE, 24'h0}, 1);
		cmd({OP_STAT_WRITE, s, 16'h0}, 2);
		settle();
	endtask : stat_write

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		#450000;
		errors++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rst_n = 1'b0;
		i_wr    = 1'b0;
		i_rd    = 1'b0;
		i_addr  = 4'h0;
		i_wdata = 32'h0;
		void'($urandom(60831));
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (10) @(posedge i_clk);
		`CHK("status", 8'h00, status)
		`CHK("released line", 1'b1, link_if.so_line)
		`CHK("idle clock mode0", 1'b0, link_if.sclk)
		cmd({OP_WR_ENABLE, 24'h0}, 1);
		cmd({OP_RDSR, 24'h0}, 2);
		rd(HREG_RX);
		`CHK("status read mode0", 8'h02, v[7:0])
		wr(HREG_CFG, 32'h1);
		repeat (4) @(posedge i_clk);
		`CHK("idle clock mode3", 1'b1, link_if.sclk)
		cmd({OP_RDSR, 24'h0}, 2);
		rd(HREG_RX);
		`CHK("status read mode3", 8'h02, v[7:0])
		cmd({OP_WR_DISABLE, 24'h0}, 1);
		`CHK("latch after disable", 8'h00, status)
		cmd({OP_SECT_ERASE, 24'h001000}, 4);
		`CHK("erase without latch", 0, ecount)
		`CHK("busy without latch", 1'b0, status[0])
		foreach (ops[i]) begin
			a = 18'($urandom);
			cmd({OP_WR_ENABLE, 24'h0}, 1);
			cmd({ops[i], 6'h0, a}, (ops[i] == OP_CE_A || ops[i] == OP_CE_B) ? 1 : 4);
			`CHK("busy in erase", 1'b1, status[0])
			`CHK("latch cleared", 1'b0, status[1])
			`CHK("active while busy", 1'b1, active)
			settle();
			`CHK("erase count", i + 1, ecount)
			`CHK("erase span", span(ops[i], a), seen)
			`CHK("standby after erase", 1'b0, active)
		end
		// Page end offset so the burst wraps inside its page
		a = {10'($urandom), 8'hfc};
		cmd({OP_WR_ENABLE, 24'h0}, 1);
		cmd({OP_PROGRAM, 6'h0, a}, 4, 1'b0);
		for (int i = 0; i < 8; i++) begin
			dat[i] = 8'($urandom);
			send(dat[i], i == 7);
		end
		`CHK("busy in program", 1'b1, status[0])
		settle();
		`CHK("program bytes", 8, wq_a.size())
		// Write walk runs by page index, so the wrapped half lands first
		for (int i = 0; i < 8 && i < wq_a.size(); i++) begin
			`CHK("program address", {a[17:8], 8'(a[7:0] + (i + 4) % 8)}, wq_a[i])
			`CHK("program data", dat[(i + 4) % 8], wq_d[i])
		end
		for (int c = 0; c < 8; c++) begin
			stat_write({3'h0, 3'(c), 2'h0});
			`CHK("protect bits", 3'(c), status[4:2])
			secs[3] = 6'($urandom);
			foreach (secs[j]) begin
				n = ecount;
				cmd({OP_WR_ENABLE, 24'h0}, 1);
				cmd({OP_SECT_ERASE, 6'h0, secs[j], 12'h000}, 4);
				settle();
				`CHK("protected erase", !prot(3'(c), secs[j]), ecount - n == 1)
			end
		end
		stat_write(8'h80);
		`CHK("status protect set", 8'h80, status)
		wr(HREG_CFG, 32'h3);
		stat_write(8'h04);
		`CHK("hardware protected", 8'h82, status)
		wr(HREG_CFG, 32'h0);
		cmd({OP_STAT_WRITE, 24'h0}, 2);
		settle();
		`CHK("protect released", 8'h00, status)
		cmd({OP_SLEEP, 24'h0}, 1);
		`CHK("deep sleep", 1'b1, sleep)
		cmd({OP_WR_ENABLE, 24'h0}, 1);
		`CHK("ignored in sleep", 1'b0, status[1])
		cmd({OP_WAKE_ID, 24'h0}, 4, 1'b0);
		send(8'h00, 1'b1);
		rd(HREG_RX);
		`CHK("identifier", ID, v[7:0])
		`CHK("awake", 1'b0, sleep)
		cmd({OP_OTP, 24'h0}, 1);
		// Unlocked security sector still takes an erase
		n = ecount;
		cmd({OP_WR_ENABLE, 24'h0}, 1);
		cmd({OP_SECT_ERASE, 24'h000000}, 4);
		settle();
		`CHK("open sector erase", n + 1, ecount)
		`CHK("sector target", 1'b1, otp_tgt)
		stat_write(8'h00);
		`CHK("sector lock", 8'h80, status)
		n = ecount;
		cmd({OP_WR_ENABLE, 24'h0}, 1);
		cmd({OP_SECT_ERASE, 24'h000000}, 4);
		settle();
		`CHK("locked sector erase", n, ecount)
		cmd({OP_WR_DISABLE, 24'h0}, 1);
		print_verdict();
	end
endmodule : tb_top
